// File: design/slicc_pkg.sv
// package: register map, field layout and capture types for the lane configuration bank
package slicc_pkg;
  // ------------------------------------------------------------
  // register indices (printed offsets, not all multiples of four)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_CONVERTER_COUNT = 12'h406;
  localparam logic [11:0] IDX_CTRL_BITS_RES = 12'h407;
  localparam logic [11:0] IDX_BITS_PER_SAMPLE = 12'h408;
  localparam logic [11:0] IDX_SAMPLES_PER_FRAME = 12'h409;
  localparam logic [11:0] IDX_DENSITY_CTRL = 12'h40a;
  localparam logic [11:0] IDX_SPARE_ONE = 12'h40b;
  localparam logic [11:0] IDX_SPARE_TWO = 12'h40c;
  localparam logic [11:0] IDX_LANE0_RX_SUM = 12'h40d;
  localparam logic [11:0] IDX_LANE0_CALC_SUM = 12'h40e;
  localparam logic [11:0] IDX_LANE1_ID = 12'h412;
  localparam logic [11:0] IDX_LANE1_RX_SUM = 12'h415;
  localparam logic [11:0] IDX_CHECKSUM_CTRL = 12'h300;
  localparam logic [11:0] IDX_FRAMES_PER_MF = 12'h405;
  // ------------------------------------------------------------
  // field positions, reset values, bus codes and the link octet count
  // ------------------------------------------------------------
  localparam int CHECKSUM_MODE_BIT = 6;
  localparam int HIGH_DENSITY_BIT = 7;
  localparam int CTRL_BITS_LSB = 6;
  localparam logic [7:0] CAPTURE_RESET = 8'h00;
  localparam logic [7:0] CHECKSUM_CTRL_RESET = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int LINK_OCTETS = 14;

  // link information octets as delivered by the lane logic, one capture per alignment sequence
  typedef struct packed {
    logic [7:0] lane_id;
    logic [7:0] scr_lanes;
    logic [7:0] octets_per_frame;
    logic [7:0] frames_per_mf;
    logic [7:0] converters;
    logic [7:0] ctrl_res;
    logic [7:0] bits_per_sample;
    logic [7:0] samples;
    logic [7:0] density_ctrl;
    logic [7:0] spare_one;
    logic [7:0] spare_two;
    logic [7:0] checksum;
    logic [7:0] did;
    logic [7:0] bid;
  } slicc_cfg_t;

  typedef struct packed {
    logic valid;
    slicc_cfg_t cfg;
  } slicc_capture_t;
endpackage : slicc_pkg

// File: design/slicc_sum.sv
// checksum engine over the received link information octets
`timescale 1ns/100ps
`default_nettype none
module slicc_sum
  import slicc_pkg::*;
(
  input wire slicc_cfg_t cfg_in,
  input wire logic mode_in,
  output logic [7:0] sum_out
);
  logic [10:0] field_sum;
  logic [10:0] octet_sum;

  // field mode adds each parameter at its own width; octet mode adds the octets whole
  always_comb begin
    field_sum = 11'h000;
    field_sum = field_sum + {3'h0, cfg_in.did};
    field_sum = field_sum + {7'h00, cfg_in.bid[3:0]};
    field_sum = field_sum + {6'h00, cfg_in.lane_id[4:0]};
    field_sum = field_sum + {10'h000, cfg_in.scr_lanes[7]};
    field_sum = field_sum + {6'h00, cfg_in.scr_lanes[4:0]};
    field_sum = field_sum + {3'h0, cfg_in.octets_per_frame};
    field_sum = field_sum + {6'h00, cfg_in.frames_per_mf[4:0]};
    field_sum = field_sum + {3'h0, cfg_in.converters};
    field_sum = field_sum + {9'h000, cfg_in.ctrl_res[7:6]};
    field_sum = field_sum + {6'h00, cfg_in.ctrl_res[4:0]};
    field_sum = field_sum + {6'h00, cfg_in.bits_per_sample[4:0]};
    field_sum = field_sum + {6'h00, cfg_in.samples[4:0]};
    field_sum = field_sum + {10'h000, cfg_in.density_ctrl[7]};
    field_sum = field_sum + {6'h00, cfg_in.density_ctrl[4:0]};
    octet_sum = 11'h000;
    octet_sum = octet_sum + {3'h0, cfg_in.did} + {3'h0, cfg_in.bid};
    octet_sum = octet_sum + {3'h0, cfg_in.lane_id} + {3'h0, cfg_in.scr_lanes};
    octet_sum = octet_sum + {3'h0, cfg_in.octets_per_frame} + {3'h0, cfg_in.frames_per_mf};
    octet_sum = octet_sum + {3'h0, cfg_in.converters} + {3'h0, cfg_in.ctrl_res};
    octet_sum = octet_sum + {3'h0, cfg_in.bits_per_sample} + {3'h0, cfg_in.samples};
    octet_sum = octet_sum + {3'h0, cfg_in.density_ctrl};
    octet_sum = octet_sum + {3'h0, cfg_in.spare_one} + {3'h0, cfg_in.spare_two};
    sum_out = mode_in ? octet_sum[7:0] : field_sum[7:0];
  end
endmodule : slicc_sum
`default_nettype wire

// File: design/slicc_bank.sv
// captured lane configuration bank with an ahb-lite register port
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
module slicc_bank
  import slicc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire slicc_capture_t lane0_in,
  input wire slicc_capture_t lane1_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic lane0_sum_match_out
);
  // ------------------------------------------------------------
  // captured state
  // ------------------------------------------------------------
  slicc_cfg_t lane0_cfg;
  logic [7:0] lane0_calc_sum;
  logic [7:0] lane1_id_field;
  logic [7:0] lane1_rx_sum;
  logic [7:0] checksum_ctrl;
  logic [7:0] next_calc_sum;

  // ------------------------------------------------------------
  // bus state
  // ------------------------------------------------------------
  logic wr_pending;
  logic [11:0] wr_index;
  logic [11:0] rd_index;
  logic rd_now;

  function automatic logic [11:0] word_index(input logic [31:0] addr);
    word_index = addr[13:2];
  endfunction : word_index

  // ------------------------------------------------------------
  // checksum
  // ------------------------------------------------------------
  // computed from the incoming octets so the result lands with the capture
  slicc_sum u_sum (
    .cfg_in(lane0_in.cfg),
    .mode_in(checksum_ctrl[CHECKSUM_MODE_BIT]),
    .sum_out(next_calc_sum)
  );

  // whole octets are kept; the minus-one coding is the sender's and is stored as sent
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane0_cfg <= '0;
    end else if (lane0_in.valid) begin
      lane0_cfg <= lane0_in.cfg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane0_calc_sum <= CAPTURE_RESET;
    end else if (lane0_in.valid) begin
      lane0_calc_sum <= next_calc_sum;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane1_id_field <= CAPTURE_RESET;
      lane1_rx_sum <= CAPTURE_RESET;
    end else if (lane1_in.valid) begin
      lane1_id_field <= {3'h0, lane1_in.cfg.lane_id[4:0]};
      lane1_rx_sum <= lane1_in.cfg.checksum;
    end
  end

  // registered from the values the capture takes, so it flips on the capture edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane0_sum_match_out <= 1'h1;
    end else if (lane0_in.valid) begin
      lane0_sum_match_out <= (next_calc_sum == lane0_in.cfg.checksum);
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign rd_now = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ) && !hwrite_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pending <= 1'b0;
      wr_index <= 12'h000;
    end else if (hready_in) begin
      wr_pending <= hsel_in && htrans_in[1] && hwrite_in;
      wr_index <= word_index(haddr_in);
    end
  end

  // only the checksum control accepts writes; capture registers drop them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      checksum_ctrl <= CHECKSUM_CTRL_RESET;
    end else if (wr_pending && wr_index == IDX_CHECKSUM_CTRL) begin
      checksum_ctrl <= hwdata_in[7:0];
    end
  end

  assign rd_index = word_index(haddr_in);

  // read data is registered at the address phase and stands in the data phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_now) begin
      case (rd_index)
        IDX_CONVERTER_COUNT: hrdata_out <= {24'h0, lane0_cfg.converters};
        IDX_CTRL_BITS_RES: hrdata_out <= {24'h0, lane0_cfg.ctrl_res};
        IDX_BITS_PER_SAMPLE: hrdata_out <= {24'h0, lane0_cfg.bits_per_sample};
        IDX_SAMPLES_PER_FRAME: hrdata_out <= {24'h0, lane0_cfg.samples};
        IDX_DENSITY_CTRL: hrdata_out <= {24'h0, lane0_cfg.density_ctrl};
        IDX_SPARE_ONE: hrdata_out <= {24'h0, lane0_cfg.spare_one};
        IDX_SPARE_TWO: hrdata_out <= {24'h0, lane0_cfg.spare_two};
        IDX_LANE0_RX_SUM: hrdata_out <= {24'h0, lane0_cfg.checksum};
        IDX_LANE0_CALC_SUM: hrdata_out <= {24'h0, lane0_calc_sum};
        IDX_LANE1_ID: hrdata_out <= {24'h0, lane1_id_field};
        IDX_LANE1_RX_SUM: hrdata_out <= {24'h0, lane1_rx_sum};
        IDX_FRAMES_PER_MF: hrdata_out <= {24'h0, lane0_cfg.frames_per_mf};
        IDX_CHECKSUM_CTRL: hrdata_out <= {24'h0, checksum_ctrl};
        default: hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_hold_lane0;
    @(posedge clk_in) disable iff (rst_in)
      !lane0_in.valid |=> $stable(lane0_cfg);
  endproperty
  a_hold_lane0: assert property (p_hold_lane0) else $error("lane 0 capture moved");

  property p_capture_conv;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.converters == $past(lane0_in.cfg.converters);
  endproperty
  a_capture_conv: assert property (p_capture_conv) else $error("converter count lost");

  property p_capture_sum0;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.checksum == $past(lane0_in.cfg.checksum);
  endproperty
  a_capture_sum0: assert property (p_capture_sum0) else $error("lane 0 sum lost");

  property p_calc_sum;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_calc_sum == $past(next_calc_sum);
  endproperty
  a_calc_sum: assert property (p_calc_sum) else $error("computed sum wrong");

  property p_lid_top;
    @(posedge clk_in) disable iff (rst_in)
      lane1_id_field[7:5] == 3'h0;
  endproperty
  a_lid_top: assert property (p_lid_top) else $error("lane id top bits set");

  property p_lane1_sum;
    @(posedge clk_in) disable iff (rst_in)
      lane1_in.valid |=> lane1_rx_sum == $past(lane1_in.cfg.checksum);
  endproperty
  a_lane1_sum: assert property (p_lane1_sum) else $error("lane 1 sum lost");

  property p_hold_lane1;
    @(posedge clk_in) disable iff (rst_in)
      !lane1_in.valid |=> $stable(lane1_rx_sum) && $stable(lane1_id_field);
  endproperty
  a_hold_lane1: assert property (p_hold_lane1) else $error("lane 1 capture moved");

  property p_read_hd;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_DENSITY_CTRL
        |=> hrdata_out[HIGH_DENSITY_BIT] == $past(lane0_cfg.density_ctrl[7]);
  endproperty
  a_read_hd: assert property (p_read_hd) else $error("density flag misread");

  property p_read_calc;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_LANE0_CALC_SUM |=> hrdata_out[7:0] == $past(lane0_calc_sum);
  endproperty
  a_read_calc: assert property (p_read_calc) else $error("computed sum misread");

  property p_capture_ctrl;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.ctrl_res == $past(lane0_in.cfg.ctrl_res);
  endproperty
  a_capture_ctrl: assert property (p_capture_ctrl) else $error("ctrl and resolution lost");

  property p_capture_np;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.bits_per_sample == $past(lane0_in.cfg.bits_per_sample);
  endproperty
  a_capture_np: assert property (p_capture_np) else $error("bits per sample lost");

  property p_capture_samples;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.samples == $past(lane0_in.cfg.samples);
  endproperty
  a_capture_samples: assert property (p_capture_samples) else $error("samples lost");

  property p_capture_density;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.density_ctrl == $past(lane0_in.cfg.density_ctrl);
  endproperty
  a_capture_density: assert property (p_capture_density) else $error("density lost");

  property p_capture_spare;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.spare_one == $past(lane0_in.cfg.spare_one)
        && lane0_cfg.spare_two == $past(lane0_in.cfg.spare_two);
  endproperty
  a_capture_spare: assert property (p_capture_spare) else $error("spare octets lost");

  property p_capture_frames;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_cfg.frames_per_mf == $past(lane0_in.cfg.frames_per_mf);
  endproperty
  a_capture_frames: assert property (p_capture_frames) else $error("frames lost");

  property p_lane1_id;
    @(posedge clk_in) disable iff (rst_in)
      lane1_in.valid |=> lane1_id_field[4:0] == $past(lane1_in.cfg.lane_id[4:0]);
  endproperty
  a_lane1_id: assert property (p_lane1_id) else $error("lane 1 id lost");

  property p_calc_hold;
    @(posedge clk_in) disable iff (rst_in)
      !lane0_in.valid |=> $stable(lane0_calc_sum);
  endproperty
  a_calc_hold: assert property (p_calc_hold) else $error("computed sum moved");

  property p_match_flag;
    @(posedge clk_in) disable iff (rst_in)
      lane0_in.valid |=> lane0_sum_match_out
        == ($past(next_calc_sum) == $past(lane0_in.cfg.checksum));
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag wrong");

  property p_match_hold;
    @(posedge clk_in) disable iff (rst_in)
      !lane0_in.valid |=> $stable(lane0_sum_match_out);
  endproperty
  a_match_hold: assert property (p_match_hold) else $error("match flag moved");

  property p_ctrl_write;
    @(posedge clk_in) disable iff (rst_in)
      wr_pending && wr_index == IDX_CHECKSUM_CTRL |=> checksum_ctrl == $past(hwdata_in[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("mode write lost");

  property p_ctrl_hold;
    @(posedge clk_in) disable iff (rst_in)
      !(wr_pending && wr_index == IDX_CHECKSUM_CTRL) |=> $stable(checksum_ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("mode moved");

  property p_read_conv;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_CONVERTER_COUNT
        |=> hrdata_out == {24'h0, $past(lane0_cfg.converters)};
  endproperty
  a_read_conv: assert property (p_read_conv) else $error("converter count misread");

  property p_read_ctrl_res;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_CTRL_BITS_RES
        |=> hrdata_out == {24'h0, $past(lane0_cfg.ctrl_res)};
  endproperty
  a_read_ctrl_res: assert property (p_read_ctrl_res) else $error("resolution misread");

  property p_read_np;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_BITS_PER_SAMPLE
        |=> hrdata_out == {24'h0, $past(lane0_cfg.bits_per_sample)};
  endproperty
  a_read_np: assert property (p_read_np) else $error("bits per sample misread");

  property p_read_cf;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_DENSITY_CTRL
        |=> hrdata_out[4:0] == $past(lane0_cfg.density_ctrl[4:0]);
  endproperty
  a_read_cf: assert property (p_read_cf) else $error("ctrl words misread");

  property p_read_sum0;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_LANE0_RX_SUM
        |=> hrdata_out == {24'h0, $past(lane0_cfg.checksum)};
  endproperty
  a_read_sum0: assert property (p_read_sum0) else $error("lane 0 sum misread");

  property p_read_lid;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_LANE1_ID
        |=> hrdata_out == {24'h0, 3'h0, $past(lane1_id_field[4:0])};
  endproperty
  a_read_lid: assert property (p_read_lid) else $error("lane 1 id misread");

  property p_read_sum1;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_LANE1_RX_SUM
        |=> hrdata_out == {24'h0, $past(lane1_rx_sum)};
  endproperty
  a_read_sum1: assert property (p_read_sum1) else $error("lane 1 sum misread");

  property p_read_frames;
    @(posedge clk_in) disable iff (rst_in)
      rd_now && rd_index == IDX_FRAMES_PER_MF
        |=> hrdata_out == {24'h0, $past(lane0_cfg.frames_per_mf)};
  endproperty
  a_read_frames: assert property (p_read_frames) else $error("frames misread");

  property p_read_hold;
    @(posedge clk_in) disable iff (rst_in)
      !rd_now |=> $stable(hrdata_out);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
endmodule : slicc_bank
`default_nettype wire

// File: tb/slicc_tx_model.sv
// transmitter model: one link configuration burst per request on one lane
`timescale 1ns/100ps
`default_nettype none
module slicc_tx_model
  import slicc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic send_in,
  input wire slicc_cfg_t cfg_in,
  output slicc_capture_t lane_out
);
  // ------------------------------------------------------------
  // burst driver
  // ------------------------------------------------------------
  // the bench supplies every octet, sum included, so expected sums stay hand-worked
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane_out <= '0;
    end else if (send_in) begin
      lane_out <= {1'b1, cfg_in};
    end else begin
      // idle octets toggle so stale values never pass for a capture
      lane_out <= {1'b0, ~lane_out.cfg};
    end
  end
endmodule : slicc_tx_model
`default_nettype wire

// File: tb/tb_top.sv
// testbench: register reads, captures on both lanes, write protection
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import slicc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, s0 = 1'b0, s1 = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hready, hresp, match;
  slicc_cfg_t c0 = '0, c1 = '0;
  slicc_capture_t l0, l1;
  int fails = 0, n_checks = 0;
  logic [11:0] ix [13] = '{IDX_CONVERTER_COUNT, IDX_CTRL_BITS_RES, IDX_BITS_PER_SAMPLE,
    IDX_SAMPLES_PER_FRAME, IDX_DENSITY_CTRL, IDX_SPARE_ONE, IDX_SPARE_TWO, IDX_LANE0_RX_SUM,
    IDX_LANE0_CALC_SUM, IDX_LANE1_ID, IDX_LANE1_RX_SUM, IDX_FRAMES_PER_MF, IDX_CHECKSUM_CTRL};

  always #25 clk_in = ~clk_in;

  slicc_tx_model tx0 (.clk_in(clk_in), .rst_in(rst_in), .send_in(s0), .cfg_in(c0), .lane_out(l0));
  slicc_tx_model tx1 (.clk_in(clk_in), .rst_in(rst_in), .send_in(s1), .cfg_in(c1), .lane_out(l1));
  slicc_bank dut (.clk_in(clk_in), .rst_in(rst_in), .lane0_in(l0), .lane1_in(l1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .lane0_sum_match_out(match));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk

  // request on one lane; capture lands at the edge after return
  task automatic send(input logic lane);
    @(posedge clk_in);
    if (lane) s1 <= 1'b1;
    else s0 <= 1'b1;
    @(posedge clk_in);
    s0 <= 1'b0;
    s1 <= 1'b0;
  endtask : send

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    foreach (ix[i]) rchk("reset value", ix[i], 32'h0);
    chk("match after reset", {31'h0, match}, 32'h1);
  endtask : t_reset

  task automatic t_lane0();
    bus(IDX_CHECKSUM_CTRL, 1'b1, 32'h40);
    rchk("checksum mode", IDX_CHECKSUM_CTRL, 32'h40);
    // M=2, CS=0, N=16, NP=16, S=1, HD=1, CF=0, K=32; sum of the other 13 octets
    c0 <= {8'h00, 8'h00, 8'h01, 8'h1f, 8'h01, 8'h0f, 8'h0f, 8'h00, 8'h80, 8'ha5, 8'h3c,
      8'hb5, 8'h12, 8'h03};
    send(1'b0);
    rchk("converters", IDX_CONVERTER_COUNT, 32'h01);
    rchk("ctrl and resolution", IDX_CTRL_BITS_RES, 32'h0f);
    rchk("bits per sample", IDX_BITS_PER_SAMPLE, 32'h0f);
    rchk("samples", IDX_SAMPLES_PER_FRAME, 32'h00);
    rchk("density and ctrl words", IDX_DENSITY_CTRL, 32'h80);
    rchk("spare one", IDX_SPARE_ONE, 32'ha5);
    rchk("spare two", IDX_SPARE_TWO, 32'h3c);
    rchk("frames per mf", IDX_FRAMES_PER_MF, 32'h1f);
    rchk("lane0 rx sum", IDX_LANE0_RX_SUM, 32'hb5);
    rchk("lane0 calc sum", IDX_LANE0_CALC_SUM, 32'hb5);
    chk("sum match", {31'h0, match}, 32'h1);
  endtask : t_lane0

  task automatic t_protect();
    bus(IDX_CONVERTER_COUNT, 1'b1, 32'hff);
    rchk("write ignored", IDX_CONVERTER_COUNT, 32'h01);
    rchk("unmapped", 12'h7f0, 32'h0);
    bus(IDX_CHECKSUM_CTRL, 1'b1, 32'h0);
    rchk("sum kept over mode change", IDX_LANE0_CALC_SUM, 32'hb5);
  endtask : t_protect

  // field mode: the stale octet-mode sum first, then the matching one
  task automatic t_field();
    send(1'b0);
    rchk("field calc sum", IDX_LANE0_CALC_SUM, 32'h55);
    chk("sum mismatch flagged", {31'h0, match}, 32'h0);
    c0.checksum <= 8'h55;
    send(1'b0);
    rchk("field rx sum", IDX_LANE0_RX_SUM, 32'h55);
    chk("field sum match", {31'h0, match}, 32'h1);
  endtask : t_field

  task automatic t_lane1();
    c1 <= {8'he3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00,
      8'hf3, 8'h00, 8'h00};
    send(1'b1);
    rchk("lane1 id", IDX_LANE1_ID, 32'h03);
    rchk("lane1 rx sum", IDX_LANE1_RX_SUM, 32'hf3);
    rchk("lane0 untouched", IDX_LANE0_RX_SUM, 32'h55);
  endtask : t_lane1

  // mid-run reset after captures and a mode write clears every register and sets the match flag
  task automatic t_rerst();
    bus(IDX_CHECKSUM_CTRL, 1'b1, 32'h40);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
  endtask : t_rerst

  task automatic give_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_lane0();
    t_protect();
    t_field();
    t_lane1();
    t_rerst();
    give_verdict();
  end

  // run needs about 160 cycles
  initial begin
    #(3000 * 50);
    fails++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
